// ===== design/erb_consts.svh
// Notes on behaviour
// - Register address pins are driven on every access and held latched.
// - The address selects one of up to seven external registers.
// - The eighth external slot is never given to peripherals.
// - Data lines float except on external writes or port outputs.
// - Data strobe goes low only for external register transfers.
// - Direction high means read; write data drives while both are low.
// - Wait input is sampled on the rising clock edge to extend access.
// - Wait-state enable inserts exactly one internal wait state.
// - An enabled port takes over all sixteen data lines.
// - Per-bit port direction; open-drain drive chosen for the whole port.
// - Port configuration writes reach the pins one cycle after the write.
// - Upper port byte can be handed to the second port.
`ifndef ERB_CONSTS_SVH
`define ERB_CONSTS_SVH

// ========================================================================
// Register map, byte addresses.
`define ERB_OFF_CTRL 8'h00
`define ERB_OFF_DIR 8'h04
`define ERB_OFF_OUT 8'h08
`define ERB_OFF_PIN 8'h0c
`define ERB_OFF_SECOND 8'h10
`define ERB_EXT_PAGE 3'h2
`define ERB_RESERVED_SLOT 3'h7

// ========================================================================
// Control register fields.
`define ERB_CTRL_WS_EN 0
`define ERB_CTRL_PORT_EN 1
`define ERB_CTRL_OPEN_DRAIN 2
`define ERB_CTRL_HI_SECOND 3
`define ERB_CTRL_RESET 4'h0
`define ERB_HALF_RESET 16'h0000

`endif

// ===== design/erb_pkg.sv
package erb_pkg;

    // Gray codes along idle, strobe, internal wait, finish.
    typedef enum logic [1:0] {
        ERB_IDLE = 2'b00,
        ERB_STROBE = 2'b01,
        ERB_WAIT = 2'b11,
        ERB_FINISH = 2'b10
    } erb_state_t;

    typedef struct packed {
        logic hi_second;
        logic open_drain;
        logic port_en;
        logic ws_en;
    } erb_cfg_t;

    typedef struct packed {
        logic [2:0] addr;
        logic strobe_n;
        logic rd_wr;
    } erb_bus_t;

endpackage : erb_pkg

// ===== design/erb_port.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "erb_consts.svh"

module erb_port (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // External register bus.
    output logic [2:0] ext_reg_addr_out,
    output logic data_strobe_n_out,
    output logic rd_wr_out,
    input wire logic wait_n_in,
    // Shared data lines.
    input wire logic [15:0] ext_data_lines_in,
    output logic [15:0] ext_data_lines_out,
    output logic [15:0] ext_data_lines_oe_out
);

    // ====================================================================
    // Decode.
    erb_pkg::erb_state_t state;
    erb_pkg::erb_cfg_t cfg;
    erb_pkg::erb_bus_t bus;
    logic [15:0] port_dir;
    logic [15:0] port_out;
    logic [15:0] second_cfg;
    logic [15:0] wdata;
    logic ws_done;
    logic setup;
    logic acc_done;
    logic is_ext;
    logic is_reserved;
    logic ext_ok;
    logic int_hit;
    logic end_now;
    logic in_strobe;
    logic bus_wr_next;
    logic [15:0] next_wdata;
    logic [15:0] sel_dir;
    logic [15:0] sel_val;
    logic [31:0] rd_mux;

    assign setup = psel_in && !penable_in && !pready_out
        && (state == erb_pkg::ERB_IDLE);
    assign acc_done = psel_in && penable_in && pready_out;
    assign is_ext = (paddr_in[7:5] == `ERB_EXT_PAGE);
    assign is_reserved = (paddr_in[4:2] == `ERB_RESERVED_SLOT);
    // External traffic is refused while the port owns the lines.
    assign ext_ok = is_ext && !is_reserved && !cfg.port_en;
    assign in_strobe = (state == erb_pkg::ERB_STROBE)
        || (state == erb_pkg::ERB_WAIT);
    // Strobe ends once wait is released and any internal wait is spent.
    assign end_now = in_strobe && wait_n_in
        && (!cfg.ws_en || ws_done);

    always_comb begin
        int_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            `ERB_OFF_CTRL: rd_mux = {28'h0000_000, cfg};
            `ERB_OFF_DIR: rd_mux = {16'h0000, port_dir};
            `ERB_OFF_OUT: rd_mux = {16'h0000, port_out};
            `ERB_OFF_PIN: rd_mux = {16'h0000, ext_data_lines_in};
            `ERB_OFF_SECOND: rd_mux = {16'h0000, second_cfg};
            default: int_hit = 1'b0;
        endcase
    end

    // ====================================================================
    // APB answer.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else if (acc_done) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (setup && !ext_ok) begin
            pready_out <= 1'b1;
            pslverr_out <= !int_hit;
            prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
        end else if (end_now) begin
            pready_out <= 1'b1;
            prdata_out <= bus.rd_wr ? {16'h0000, ext_data_lines_in}
                : 32'h0000_0000;
        end
    end

    // ====================================================================
    // Configuration registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg <= `ERB_CTRL_RESET;
            port_dir <= `ERB_HALF_RESET;
            port_out <= `ERB_HALF_RESET;
            second_cfg <= `ERB_HALF_RESET;
        end else if (acc_done && pwrite_in && !pslverr_out) begin
            case (paddr_in)
                `ERB_OFF_CTRL: cfg <= pwdata_in[3:0];
                `ERB_OFF_DIR: port_dir <= pwdata_in[15:0];
                `ERB_OFF_OUT: port_out <= pwdata_in[15:0];
                `ERB_OFF_SECOND: second_cfg <= pwdata_in[15:0];
                default: ;
            endcase
        end
    end

    // ====================================================================
    // External bus sequencer.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= erb_pkg::ERB_IDLE;
            bus <= {3'h0, 1'b1, 1'b1};
            wdata <= 16'h0000;
            ws_done <= 1'b0;
        end else begin
            case (state)
                erb_pkg::ERB_IDLE: begin
                    if (setup) begin
                        bus.addr <= paddr_in[4:2];
                        if (ext_ok) begin
                            state <= erb_pkg::ERB_STROBE;
                            bus.strobe_n <= 1'b0;
                            bus.rd_wr <= !pwrite_in;
                            wdata <= pwdata_in[15:0];
                            ws_done <= 1'b0;
                        end
                    end
                end
                erb_pkg::ERB_STROBE, erb_pkg::ERB_WAIT: begin
                    if (end_now) begin
                        state <= erb_pkg::ERB_FINISH;
                        bus.strobe_n <= 1'b1;
                        bus.rd_wr <= 1'b1;
                    end else if (wait_n_in) begin
                        state <= erb_pkg::ERB_WAIT;
                        ws_done <= 1'b1;
                    end
                end
                erb_pkg::ERB_FINISH: begin
                    if (acc_done) begin
                        state <= erb_pkg::ERB_IDLE;
                    end
                end
                default: state <= erb_pkg::ERB_IDLE;
            endcase
        end
    end

    assign ext_reg_addr_out = bus.addr;
    assign data_strobe_n_out = bus.strobe_n;
    assign rd_wr_out = bus.rd_wr;

    // ====================================================================
    // Data line drivers.
    // Pins follow the configuration one cycle after a write; the flop
    // keeps the pin outputs glitch free at the cost of that cycle.
    assign bus_wr_next = (setup && ext_ok && pwrite_in)
        || (in_strobe && !bus.rd_wr && !end_now);
    assign next_wdata = (state == erb_pkg::ERB_IDLE) ? pwdata_in[15:0]
        : wdata;
    assign sel_dir = cfg.hi_second ? {second_cfg[15:8], port_dir[7:0]}
        : port_dir;
    assign sel_val = cfg.hi_second ? {second_cfg[7:0], port_out[7:0]}
        : port_out;

    for (genvar i = 0; i < 16; i++) begin : g_pin
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                ext_data_lines_oe_out[i] <= 1'b0;
                ext_data_lines_out[i] <= 1'b0;
            end else if (bus_wr_next) begin
                ext_data_lines_oe_out[i] <= 1'b1;
                ext_data_lines_out[i] <= next_wdata[i];
            end else begin
                ext_data_lines_oe_out[i] <= cfg.port_en && sel_dir[i]
                    && !(cfg.open_drain && sel_val[i]);
                ext_data_lines_out[i] <= sel_val[i] && !cfg.open_drain;
            end
        end
    end

    // ====================================================================
    // Checks.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_strobe_ext_only:
    assert property (setup && !ext_ok |=> data_strobe_n_out)
        else $error("Strobe asserted on a non-external access.");

    a_reserved_slot_free:
    assert property (!data_strobe_n_out |-> ext_reg_addr_out != 3'h7)
        else $error("Strobe asserted for the reserved slot.");

    a_write_drives_lines:
    assert property (!data_strobe_n_out && !rd_wr_out
        |-> ext_data_lines_oe_out == 16'hffff)
        else $error("Write data not driven during write strobe.");

    a_lines_float_idle:
    assert property (!cfg.port_en && data_strobe_n_out
        |=> !data_strobe_n_out || ext_data_lines_oe_out == 16'h0000)
        else $error("Data lines driven outside write or port use.");

    a_wait_extends:
    assert property (in_strobe && !wait_n_in |=> !data_strobe_n_out)
        else $error("Strobe ended while wait was asserted.");

    a_one_wait_state:
    assert property ($fell(data_strobe_n_out) && cfg.ws_en && wait_n_in
        ##1 wait_n_in |=> data_strobe_n_out)
        else $error("Internal wait state not exactly one cycle.");

    a_wait_inserted:
    assert property ($fell(data_strobe_n_out) && cfg.ws_en
        |=> !data_strobe_n_out)
        else $error("Internal wait state missing.");

    a_addr_held:
    assert property (!data_strobe_n_out && $past(!data_strobe_n_out)
        |-> $stable(ext_reg_addr_out))
        else $error("Register address moved during a strobe.");

    a_read_capture:
    assert property ($rose(data_strobe_n_out) && $past(rd_wr_out)
        |-> prdata_out == {16'h0000, $past(ext_data_lines_in)})
        else $error("Read data not taken at strobe end.");

    a_open_drain_low:
    assert property (cfg.port_en && cfg.open_drain
        |=> (ext_data_lines_out & ext_data_lines_oe_out) == 16'h0000
        || !data_strobe_n_out)
        else $error("Open-drain port drove a line high.");

    // Pin checks look one edge ahead, because the pin flops follow the
    // configuration one cycle late.
    a_strobe_on_ext:
    assert property (setup && ext_ok |=> !data_strobe_n_out)
        else $error("Strobe missing on an external access.");

    a_addr_latched:
    assert property (setup |=> ext_reg_addr_out == $past(paddr_in[4:2]))
        else $error("Register address not taken from the request.");

    a_addr_idle_hold:
    assert property (!setup |=> $stable(ext_reg_addr_out))
        else $error("Register address moved between accesses.");

    a_read_dir_high:
    assert property (setup && ext_ok && !pwrite_in |=> rd_wr_out)
        else $error("Direction select low on a read.");

    a_write_dir_low:
    assert property (setup && ext_ok && pwrite_in |=> !rd_wr_out)
        else $error("Direction select high on a write.");

    a_dir_idle_high:
    assert property (data_strobe_n_out |-> rd_wr_out)
        else $error("Direction select low outside a strobe.");

    a_write_data_out:
    assert property (setup && ext_ok && pwrite_in
        |=> ext_data_lines_out == $past(pwdata_in[15:0]))
        else $error("Write data not placed on the data lines.");

    a_write_data_hold:
    assert property (!data_strobe_n_out && !rd_wr_out
        |=> data_strobe_n_out || $stable(ext_data_lines_out))
        else $error("Write data moved during the strobe.");

    a_read_lines_free:
    assert property (!data_strobe_n_out && rd_wr_out
        |-> ext_data_lines_oe_out == 16'h0000)
        else $error("Data lines driven during a read strobe.");

    a_refused_port_on:
    assert property (setup && is_ext && cfg.port_en
        |=> data_strobe_n_out && pslverr_out)
        else $error("External access not refused while the port is on.");

    a_reserved_error:
    assert property (setup && is_ext && is_reserved |=> pslverr_out)
        else $error("Reserved slot access not refused.");

    a_wait_sampled:
    assert property (in_strobe && wait_n_in && !cfg.ws_en
        |=> data_strobe_n_out)
        else $error("Strobe held although wait was released.");

    a_ready_at_end:
    assert property ($rose(data_strobe_n_out) |-> pready_out)
        else $error("Answer missing at the end of the strobe.");

    a_strobe_no_err:
    assert property ($rose(data_strobe_n_out) |-> !pslverr_out)
        else $error("External transfer answered with an error.");

    a_read_upper_zero:
    assert property ($rose(data_strobe_n_out)
        |-> prdata_out[31:16] == 16'h0000)
        else $error("Upper read data bits not zero.");

    a_port_float_off:
    assert property (!cfg.port_en && data_strobe_n_out && !setup
        |=> ext_data_lines_oe_out == 16'h0000)
        else $error("Data lines driven with the port off and no write.");

    a_port_drive:
    assert property (cfg.port_en && !cfg.open_drain && !cfg.hi_second
        |=> ext_data_lines_oe_out == $past(port_dir)
        && ext_data_lines_out == $past(port_out))
        else $error("Port pins do not follow direction and value.");

    a_open_drain_oe:
    assert property (cfg.port_en && cfg.open_drain && !cfg.hi_second
        |=> ext_data_lines_oe_out == $past(port_dir & ~port_out))
        else $error("Open-drain port enable not direction and low value.");

    a_upper_second:
    assert property (cfg.port_en && cfg.hi_second && !cfg.open_drain
        |=> ext_data_lines_oe_out[15:8] == $past(second_cfg[15:8])
        && ext_data_lines_out[15:8] == $past(second_cfg[7:0]))
        else $error("Upper lines do not follow the second port.");

    a_lower_kept:
    assert property (cfg.port_en && cfg.hi_second && !cfg.open_drain
        |=> ext_data_lines_oe_out[7:0] == $past(port_dir[7:0]))
        else $error("Lower lines lost the shared port direction.");

    c_ext_read: cover property ($rose(data_strobe_n_out) && prdata_out != 0);
    c_ext_write_wait: cover property (!rd_wr_out
        && state == erb_pkg::ERB_WAIT);
    c_upper_port: cover property (cfg.port_en && cfg.hi_second);
    c_port_output: cover property (cfg.port_en && |ext_data_lines_oe_out);
    c_reserved_err: cover property (pready_out && pslverr_out);

endmodule : erb_port

// ===== verification/erb_periph.sv
`timescale 1ns/1ps
// ==========
// Peripheral register file on the far side of the bus.
module erb_periph (
    // Bus side.
    input wire logic clk_in,
    input wire logic [2:0] addr_in,
    input wire logic strobe_n_in,
    input wire logic rd_wr_in,
    input wire logic [15:0] lines_in,
    input wire logic [3:0] extra_in,
    // Answer side.
    output logic wait_n_out,
    output logic [15:0] data_out,
    output logic data_oe_out
);
    logic [15:0] regs [0:7];
    logic started = 1'b0;
    logic [3:0] cnt = 4'h0;
    // Read data is driven only inside the read window, never longer.
    assign data_oe_out = !strobe_n_in && rd_wr_in;
    assign data_out = regs[addr_in];
    // Wait is held low for as many cycles as extra time is wanted.
    assign wait_n_out = !(!strobe_n_in &&
        (started ? cnt != 4'h0 : extra_in != 4'h0));
    always @(posedge clk_in) begin
        started <= !strobe_n_in;
        if (!strobe_n_in && !started && extra_in != 4'h0) begin
            cnt <= extra_in - 4'h1;
        end else if (!strobe_n_in && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        if (!strobe_n_in && !rd_wr_in) begin
            regs[addr_in] <= lines_in;
        end
    end
endmodule : erb_periph

// ===== verification/external_register_bus_shared_gp_port_tb_top.sv
`timescale 1ns/1ps
// ==========
// Bench for the external register bus port.
module external_register_bus_shared_gp_port_tb_top;
    typedef struct {
        logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;
        logic err; int len;
    } erb_row_t;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out, rd;
    logic pready_out, pslverr_out, strobe_n, rd_wr, wait_n, p_oe, err;
    logic [2:0] addr;
    logic [15:0] lines, d_out, d_oe, p_data;
    logic [15:0] flt = 16'h5a5a;
    logic [3:0] extra = 4'h0;
    int n_mismatch = 0, n_checks = 0, cycles = 0, slen = 0;
    erb_row_t rows [13] = '{
        '{1, 8'h4c, 16'h00a5, 0, 0, 1}, '{0, 8'h4c, 0, 16'h00a5, 0, 1},
        '{1, 8'h58, 16'h1234, 0, 0, 1}, '{0, 8'h58, 0, 16'h1234, 0, 1},
        '{0, 8'h5c, 0, 0, 1, 0}, '{1, 8'h5c, 16'hffff, 0, 1, 0},
        '{1, 8'h00, 16'h0001, 0, 0, 0}, '{0, 8'h4c, 0, 16'h00a5, 0, 2},
        '{1, 8'h40, 16'hbeef, 0, 0, 2}, '{0, 8'h40, 0, 16'hbeef, 0, 2},
        '{0, 8'h00, 0, 16'h0001, 0, 0}, '{1, 8'h00, 0, 0, 0, 0},
        '{0, 8'h20, 0, 0, 1, 0}};
    always #2 clk_in = ~clk_in;
    // Undriven lines show a changing pattern so no stale value passes.
    assign lines = (d_out & d_oe) | ({16{p_oe}} & p_data) |
        (flt & ~d_oe & ~{16{p_oe}});
    erb_port i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .ext_reg_addr_out(addr), .data_strobe_n_out(strobe_n),
        .rd_wr_out(rd_wr), .wait_n_in(wait_n), .ext_data_lines_in(lines),
        .ext_data_lines_out(d_out), .ext_data_lines_oe_out(d_oe));
    erb_periph i_periph (.clk_in(clk_in), .addr_in(addr),
        .strobe_n_in(strobe_n), .rd_wr_in(rd_wr), .lines_in(lines),
        .extra_in(extra), .wait_n_out(wait_n), .data_out(p_data),
        .data_oe_out(p_oe));
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        slen <= 0;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // The answer is taken at the very edge that sees pready high.
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task settle();
        @(posedge clk_in);
        @(negedge clk_in);
    endtask : settle
    always @(posedge clk_in) begin
        flt <= ~flt;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    always @(negedge clk_in) begin
        if (strobe_n === 1'b0) slen <= slen + 1;
        if (strobe_n === 1'b0 && rd_wr === 1'b0) begin
            check("wr oe", d_oe, 16'hffff);
        end
    end
    initial begin
        repeat (3) @(negedge clk_in);
        check("strobe", strobe_n, 1'b1);
        check("oe", d_oe, 16'h0);
        check("ready", pready_out, 1'b0);
        $display("reset test done");
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, {16'h0, rows[i].d});
            check("err", err, rows[i].err);
            check("strobe len", slen, rows[i].len);
            check("addr", addr, rows[i].a[4:2]);
            check("oe idle", d_oe, 16'h0);
            check("rd_wr idle", rd_wr, 1'b1);
            if (!rows[i].w && !rows[i].err) check("rd", rd, rows[i].e);
            $display("row %0d done", i);
        end
        extra <= 4'h3;
        apb(0, 8'h40, 0);
        check("wait len", slen, 4);
        check("wait rd", rd, 32'hbeef);
        extra <= 4'h0;
        $display("wait test done");
        apb(1, 8'h04, 32'h00ff);
        apb(1, 8'h08, 32'h00a5);
        apb(1, 8'h00, 32'h2);
        settle();
        check("port oe", d_oe, 16'h00ff);
        check("port out", d_out[7:0], 8'ha5);
        apb(0, 8'h0c, 0);
        check("pin", rd[7:0], 8'ha5);
        apb(0, 8'h4c, 0);
        check("refused", {err, slen[0]}, 2'b10);
        apb(1, 8'h00, 32'h6);
        settle();
        check("od oe", d_oe, 16'h005a);
        check("od out", d_out, 16'h0);
        apb(1, 8'h10, 32'h0f3c);
        apb(1, 8'h00, 32'ha);
        settle();
        check("hi oe", d_oe[15:8], 8'h0f);
        check("hi out", d_out[11:8], 4'hc);
        apb(1, 8'h00, 32'h0);
        settle();
        check("off oe", d_oe, 16'h0);
        $display("port test done");
        // Reset at the same edge as the write that enables the port, before the pins drive, then a normal read.
        apb(1, 8'h00, 32'h2);
        rst_n_in <= 1'b0;
        settle();
        check("rst oe", d_oe, 16'h0);
        check("rst strobe", strobe_n, 1'b1);
        check("rst ready", pready_out, 1'b0);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        apb(0, 8'h58, 0);
        check("rst err", err, 1'b0);
        check("rst rd", rd, 32'h1234);
        check("rst len", slen, 1);
        $display("mid reset test done");
        close_out();
    end
endmodule : external_register_bus_shared_gp_port_tb_top
